// file: hw/slr_consts.svh
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SLR_IDX_SLEW       8'h08
`define SLR_IDX_SN_HIGH    8'h09
`define SLR_IDX_SN_MID     8'h0a
`define SLR_IDX_SN_LOW     8'h0b
`define SLR_IDX_PART_ID    8'h0c
`define SLR_IDX_ALERT_CFG  8'h10
`define SLR_IDX_CONV_MS    8'h11
`define SLR_IDX_IRQ_STAT   8'h12
`define SLR_IDX_IRQ_MASK   8'h13
`define SLR_IDX_RATE_STAT  8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SLR_SLEW_MSB       14
`define SLR_SLEW_LSB       2
`define SLR_SLEW_RST_REG   16'h0500
`define SLR_SLEW_RST       13'h0140
`define SLR_RATE_EN_BIT    3
`define SLR_CMP_MODE_BIT   8
`define SLR_IRQ_RATE_BIT   0
`define SLR_IRQ_CONV_BIT   1
`define SLR_REV_MSB        15
`define SLR_REV_LSB        12

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLR_CLK_NS         8
`define SLR_MS_NS          1000000
`define SLR_MS_CYC         (`SLR_MS_NS / `SLR_CLK_NS)
`define SLR_CONV_DEF_MS    12'h3e8
`define SLR_CONV_MIN_MS    12'h006
`define SLR_CONV_MAX_MS    12'h7d0

`endif

// file: hw/slr_conv_timer.sv
`timescale 1ns/10ps
`include "slr_consts.svh"

module slr_conv_timer #(
    parameter int unsigned CYC_PER_MS = `SLR_MS_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // period in milliseconds
    input  wire logic [11:0] period_ms_i,
    // conversion start pulse
    output logic             conv_start_o
);

    slr_pkg::slr_timer_t s_r;
    slr_pkg::slr_timer_t s_nxt;

    // free running: only the period register reaches this from the bus, so reads never upset it
    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        if (s_r.ms_cnt >= 17'(CYC_PER_MS - 1)) begin
            s_nxt.ms_cnt = 17'h00000;
            // a shortened period takes effect at the next ms tick
            if (s_r.per_cnt + 12'h001 >= period_ms_i) begin
                s_nxt.per_cnt = 12'h000;
                s_nxt.start = 1'b1;
            end else begin
                s_nxt.per_cnt = s_r.per_cnt + 12'h001;
            end
        end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + 17'h00001;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign conv_start_o = s_r.start;

    start_single_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_r.start |=> !s_r.start)
        else $error("conversion start longer than one cycle");

endmodule : slr_conv_timer

// file: hw/slr_pkg.sv
// ----------------------------------------------------------------
// state types
// ----------------------------------------------------------------
package slr_pkg;

    typedef struct packed {
        logic [12:0] slew_thr;
        logic        rate_en;
        logic        cmp_mode;
        logic [11:0] conv_ms;
        logic [1:0]  irq_st;
        logic [1:0]  irq_mask;
        logic        rate_status;
        logic [31:0] prdata;
        logic        pslverr;
    } slr_regs_t;

    typedef struct packed {
        logic [16:0] ms_cnt;
        logic [11:0] per_cnt;
        logic        start;
    } slr_timer_t;

endpackage : slr_pkg

// file: hw/slr_regs.sv
`timescale 1ns/10ps
`include "slr_consts.svh"

// Operation
// - the slew threshold is a 13-bit unsigned count of 0.03125 C/s held in bits 14:2.
// - after reset the slew register reads 0500h, a field value of 0140h or 10 C/s.
// - a rate warning rises only for a positive rate above the threshold; its enable gates only the alert_o output.
// - the 48-bit serial number reads as high, mid and low 16-bit words at three indices.
// - index 0Ch reads a 4-bit revision over a 12-bit part identifier, read only.
// - conversions run every 1 s by default, adjustable from 6 ms to 2 s.
// - register reads at any rate leave the conversion timing untouched.
// - the rate enable bit 3 gates alert_o: the sticky flag in interrupt mode, the status in comparator; irq_o is not gated.
module slr_regs #(
    parameter int unsigned CYC_PER_MS = `SLR_MS_CYC,
    parameter logic [3:0]  PART_REV   = 4'h1,   // arbitrary value
    parameter logic [11:0] PART_CODE  = 12'h5a3 // arbitrary value
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // measurement side, same clock
    input  wire logic [47:0] serial_number_i,
    input  wire logic [15:0] rate_i,
    input  wire logic        rate_valid_i,
    output logic             conv_start_o,
    output logic [11:0]      conv_period_ms_o,
    // alert and interrupt
    output logic             alert_o,
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction : hit

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  strb);
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction : merge16

    function automatic logic mapped(input logic [11:0] a);
        return hit(a, `SLR_IDX_SLEW) || hit(a, `SLR_IDX_SN_HIGH)
            || hit(a, `SLR_IDX_SN_MID) || hit(a, `SLR_IDX_SN_LOW)
            || hit(a, `SLR_IDX_PART_ID) || hit(a, `SLR_IDX_ALERT_CFG)
            || hit(a, `SLR_IDX_CONV_MS) || hit(a, `SLR_IDX_IRQ_STAT)
            || hit(a, `SLR_IDX_IRQ_MASK) || hit(a, `SLR_IDX_RATE_STAT);
    endfunction : mapped

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    slr_pkg::slr_regs_t s_r;
    slr_pkg::slr_regs_t s_nxt;

    logic        setup;
    logic        wr_en;
    logic        rate_pos;
    logic        rate_over;
    logic        rate_evt;
    logic [15:0] slew_word;
    logic [15:0] cur16;
    logic [15:0] new16;
    logic [31:0] rd_word;
    logic        conv_pulse;

    assign setup     = psel_i && !penable_i;
    assign wr_en     = psel_i && penable_i && pwrite_i;
    // reserved bits 15 and 1:0 are built as zero, never stored
    assign slew_word = {1'b0, s_r.slew_thr, 2'b00};

    // positive and strictly above the unsigned threshold
    assign rate_pos  = !rate_i[15] && (rate_i != 16'h0000);
    assign rate_over = rate_pos && (rate_i[14:0] > {2'b00, s_r.slew_thr});
    assign rate_evt  = rate_valid_i && rate_over;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        if (hit(paddr_i, `SLR_IDX_SLEW)) begin
            rd_word = {16'h0000, slew_word};
        end else if (hit(paddr_i, `SLR_IDX_SN_HIGH)) begin
            rd_word = {16'h0000, serial_number_i[47:32]};
        end else if (hit(paddr_i, `SLR_IDX_SN_MID)) begin
            rd_word = {16'h0000, serial_number_i[31:16]};
        end else if (hit(paddr_i, `SLR_IDX_SN_LOW)) begin
            rd_word = {16'h0000, serial_number_i[15:0]};
        end else if (hit(paddr_i, `SLR_IDX_PART_ID)) begin
            rd_word = {16'h0000, PART_REV, PART_CODE};
        end else if (hit(paddr_i, `SLR_IDX_ALERT_CFG)) begin
            rd_word[`SLR_RATE_EN_BIT]  = s_r.rate_en;
            rd_word[`SLR_CMP_MODE_BIT] = s_r.cmp_mode;
        end else if (hit(paddr_i, `SLR_IDX_CONV_MS)) begin
            rd_word = {20'h00000, s_r.conv_ms};
        end else if (hit(paddr_i, `SLR_IDX_IRQ_STAT)) begin
            rd_word = {30'h00000000, s_r.irq_st};
        end else if (hit(paddr_i, `SLR_IDX_IRQ_MASK)) begin
            rd_word = {30'h00000000, s_r.irq_mask};
        end else if (hit(paddr_i, `SLR_IDX_RATE_STAT)) begin
            rd_word = {31'h00000000, s_r.rate_status};
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        cur16 = 16'h0000;
        new16 = 16'h0000;

        // read data and error are latched in the setup cycle so that
        // the access cycle answers from flip-flops with no wait state
        if (setup) begin
            s_nxt.prdata  = pwrite_i ? 32'h00000000 : rd_word;
            s_nxt.pslverr = !mapped(paddr_i);
        end

        if (wr_en) begin
            if (hit(paddr_i, `SLR_IDX_SLEW)) begin
                cur16 = slew_word;
                new16 = merge16(cur16, pwdata_i[15:0], pstrb_i[1:0]);
                s_nxt.slew_thr = new16[`SLR_SLEW_MSB:`SLR_SLEW_LSB];
            end else if (hit(paddr_i, `SLR_IDX_ALERT_CFG)) begin
                cur16 = rd_word[15:0];
                new16 = merge16(cur16, pwdata_i[15:0], pstrb_i[1:0]);
                s_nxt.rate_en  = new16[`SLR_RATE_EN_BIT];
                s_nxt.cmp_mode = new16[`SLR_CMP_MODE_BIT];
            end else if (hit(paddr_i, `SLR_IDX_CONV_MS)) begin
                cur16 = {4'h0, s_r.conv_ms};
                new16 = merge16(cur16, pwdata_i[15:0], pstrb_i[1:0]);
                // out-of-range periods are clamped to the legal window
                if (new16 > {4'h0, `SLR_CONV_MAX_MS}) begin
                    s_nxt.conv_ms = `SLR_CONV_MAX_MS;
                end else if (new16 < {4'h0, `SLR_CONV_MIN_MS}) begin
                    s_nxt.conv_ms = `SLR_CONV_MIN_MS;
                end else begin
                    s_nxt.conv_ms = new16[11:0];
                end
            end else if (hit(paddr_i, `SLR_IDX_IRQ_STAT)) begin
                if (pstrb_i[0]) begin
                    s_nxt.irq_st = s_r.irq_st & ~pwdata_i[1:0];
                end
            end else if (hit(paddr_i, `SLR_IDX_IRQ_MASK)) begin
                if (pstrb_i[0]) begin
                    s_nxt.irq_mask = pwdata_i[1:0];
                end
            end
            // serial, part and rate status writes fall through here
        end

        // live comparator status follows each new rate sample
        if (rate_valid_i) begin
            s_nxt.rate_status = rate_over;
        end

        // hardware set is applied after the clear so it wins
        if (rate_evt) begin
            s_nxt.irq_st[`SLR_IRQ_RATE_BIT] = 1'b1;
        end
        if (rate_valid_i) begin
            s_nxt.irq_st[`SLR_IRQ_CONV_BIT] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r             <= '0;
            s_r.slew_thr    <= `SLR_SLEW_RST;
            s_r.conv_ms     <= `SLR_CONV_DEF_MS;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    slr_conv_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk_i        (clk_i),
        .rstn_i       (rstn_i),
        .period_ms_i  (s_r.conv_ms),
        .conv_start_o (conv_pulse)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_o         = s_r.prdata;
    assign pslverr_o        = s_r.pslverr;
    assign pready_o         = 1'b1;
    assign conv_start_o     = conv_pulse;
    assign conv_period_ms_o = s_r.conv_ms;

    // comparator mode follows the live status, interrupt mode the sticky flag
    assign alert_o = s_r.rate_en &&
                     (s_r.cmp_mode ? s_r.rate_status
                                   : s_r.irq_st[`SLR_IRQ_RATE_BIT]);
    assign irq_o   = |(s_r.irq_st & s_r.irq_mask);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    slew_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_en && hit(paddr_i, `SLR_IDX_SLEW) && (pstrb_i[1:0] == 2'b11))
        |=> (s_r.slew_thr == $past(pwdata_i[14:2])))
        else $error("slew threshold not taken from bits 14:2");

    slew_reset_a: assert property (@(posedge clk_i)
        $rose(rstn_i) |-> (slew_word == `SLR_SLEW_RST_REG))
        else $error("slew register reset value wrong");

    rate_warn_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rate_valid_i && !rate_i[15] && (rate_i[14:0] > {2'b00, s_r.slew_thr}))
        |=> (s_r.rate_status && s_r.irq_st[`SLR_IRQ_RATE_BIT]))
        else $error("rate warning missed");

    rate_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rate_valid_i && (rate_i[15] || (rate_i[14:0] <= {2'b00, s_r.slew_thr})))
        |=> !s_r.rate_status)
        else $error("rate warning raised without cause");

    serial_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_SN_MID))
        |=> (prdata_o == {16'h0000, $past(serial_number_i[31:16])}))
        else $error("serial mid word wrong");

    part_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_PART_ID))
        |=> (prdata_o[15:12] == PART_REV) && (prdata_o[11:0] == PART_CODE)
            && !pslverr_o)
        else $error("part identifier read wrong");

    period_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (s_r.conv_ms >= `SLR_CONV_MIN_MS) && (s_r.conv_ms <= `SLR_CONV_MAX_MS))
        else $error("conversion period out of range");

    alert_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        // an idle bus keeps both following cycles free of clears and config writes
        (rate_evt && s_r.rate_en && !s_r.cmp_mode && !psel_i) |=> alert_o [*2])
        else $error("rate alert not held in interrupt mode");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_SLEW))
        |=> (prdata_o[31:15] == 17'h00000) && (prdata_o[1:0] == 2'b00))
        else $error("reserved slew bits not zero");

    ro_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_en && hit(paddr_i, `SLR_IDX_PART_ID))
        |=> $stable({s_r.slew_thr, s_r.rate_en, s_r.cmp_mode, s_r.conv_ms, s_r.irq_mask}))
        else $error("read-only write disturbed state");

    slew_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_SLEW))
        |=> (prdata_o[14:2] == $past(s_r.slew_thr)))
        else $error("slew field read wrong");

    slew_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(wr_en && hit(paddr_i, `SLR_IDX_SLEW))
        |=> $stable(s_r.slew_thr))
        else $error("slew threshold changed without a write");

    neg_rate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rate_valid_i && rate_i[15])
        |=> !s_r.rate_status)
        else $error("negative rate raised a warning");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_en && hit(paddr_i, `SLR_IDX_IRQ_STAT) && pstrb_i[0] && pwdata_i[0] && !rate_valid_i)
        |=> !s_r.irq_st[`SLR_IRQ_RATE_BIT])
        else $error("rate flag not cleared by write");

    serial_high_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_SN_HIGH))
        |=> (prdata_o == {16'h0000, $past(serial_number_i[47:32])}))
        else $error("serial high word wrong");

    serial_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !pwrite_i && hit(paddr_i, `SLR_IDX_SN_LOW))
        |=> (prdata_o == {16'h0000, $past(serial_number_i[15:0])}))
        else $error("serial low word wrong");

    period_clamp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_en && hit(paddr_i, `SLR_IDX_CONV_MS) && (pstrb_i[1:0] == 2'b11)
         && (pwdata_i[15:0] > {4'h0, `SLR_CONV_MAX_MS}))
        |=> (s_r.conv_ms == `SLR_CONV_MAX_MS))
        else $error("long period not clamped");

    period_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_en && hit(paddr_i, `SLR_IDX_CONV_MS) && (pstrb_i[1:0] == 2'b11)
         && (pwdata_i[15:0] < {4'h0, `SLR_CONV_MIN_MS}))
        |=> (s_r.conv_ms == `SLR_CONV_MIN_MS))
        else $error("short period not clamped");

    period_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(wr_en && hit(paddr_i, `SLR_IDX_CONV_MS))
        |=> $stable(s_r.conv_ms))
        else $error("period changed without a write");

    alert_cmp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rate_valid_i && !rate_i[15] && (rate_i[14:0] > {2'b00, s_r.slew_thr})
         && s_r.rate_en && s_r.cmp_mode && !psel_i)
        |=> alert_o)
        else $error("rate alert missed in comparator mode");

    alert_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !s_r.rate_en |-> !alert_o)
        else $error("rate alert raised while disabled");

    read_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (setup && !mapped(paddr_i))
        |=> (pslverr_o && (prdata_o == 32'h00000000)))
        else $error("unmapped access not refused");

endmodule : slr_regs

// file: tb/slew_limit_and_id_registers_tb_top.sv
`timescale 1ns/10ps
`include "slr_consts.svh"
module slew_limit_and_id_registers_tb_top;
    localparam logic [11:0] A_SLEW = {2'b00, `SLR_IDX_SLEW, 2'b00};
    localparam logic [11:0] A_SNH  = {2'b00, `SLR_IDX_SN_HIGH, 2'b00};
    localparam logic [11:0] A_SNM  = {2'b00, `SLR_IDX_SN_MID, 2'b00};
    localparam logic [11:0] A_SNL  = {2'b00, `SLR_IDX_SN_LOW, 2'b00};
    localparam logic [11:0] A_ID   = {2'b00, `SLR_IDX_PART_ID, 2'b00};
    localparam logic [11:0] A_CFG  = {2'b00, `SLR_IDX_ALERT_CFG, 2'b00};
    localparam logic [11:0] A_CONV = {2'b00, `SLR_IDX_CONV_MS, 2'b00};
    localparam logic [11:0] A_IST  = {2'b00, `SLR_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_IMSK = {2'b00, `SLR_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_RST  = {2'b00, `SLR_IDX_RATE_STAT, 2'b00};
    localparam logic [47:0] SERIAL = 48'h1234_5678_9abc;
    localparam logic [3:0]  ID_REV  = 4'h3;   // arbitrary value
    localparam logic [11:0] ID_CODE = 12'h0c5; // arbitrary value
    logic        clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, alert, irq;
    logic        conv_start, rate_valid;
    logic [11:0] paddr, conv_ms;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [15:0] rate, rate_cmd;
    logic        err;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          gap_cnt    = 0;
    int          last_gap   = 0;

    slr_regs #(.CYC_PER_MS(10), .PART_REV(ID_REV), .PART_CODE(ID_CODE)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .serial_number_i(SERIAL), .rate_i(rate), .rate_valid_i(rate_valid),
        .conv_start_o(conv_start), .conv_period_ms_o(conv_ms),
        .alert_o(alert), .irq_o(irq));
    slr_meas_model model (
        .clk_i(clk_i), .rstn_i(rstn_i), .conv_start_i(conv_start),
        .rate_cmd_i(rate_cmd), .rate_o(rate), .rate_valid_o(rate_valid));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // gap between conversion starts, sampled where outputs are settled
    always @(negedge clk_i) begin
        gap_cnt = gap_cnt + 1;
        if (conv_start === 1'b1) begin
            last_gap = gap_cnt;
            gap_cnt  = 0;
        end
    end

    task automatic finish_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(32'h0, 32'h1, "apb timeout");
            finish_test();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd & mask, exp, "register read");
    endtask : chk_rd

    task automatic wait_start;
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (conv_start !== 1'b1 && n < 12000);
        if (n >= 12000) begin
            check(32'h0, 32'h1, "conversion timeout");
            finish_test();
        end
    endtask : wait_start

    // drive one rate sample through the model and let its status settle
    task automatic sample(input logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        rate_cmd <= r;
        // only a start after the new command is sure to carry it
        wait_start();
        do begin
            @(negedge clk_i);
            n++;
        end while (rate_valid !== 1'b1 && n < 12000);
        if (n >= 12000) begin
            check(32'h0, 32'h1, "sample timeout");
            finish_test();
        end
        @(negedge clk_i);
    endtask : sample

    initial begin
        rstn_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; pstrb = 4'hf; rate_cmd = 16'h0000;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        chk_rd(A_SLEW, 32'hffffffff, 32'h0000_0500);
        chk_rd(A_ID, 32'hffffffff, {16'h0, ID_REV, ID_CODE});
        chk_rd(A_SNH, 32'hffffffff, {16'h0, SERIAL[47:32]});
        chk_rd(A_SNM, 32'hffffffff, {16'h0, SERIAL[31:16]});
        chk_rd(A_SNL, 32'hffffffff, {16'h0, SERIAL[15:0]});
        check({20'h0, conv_ms}, {20'h0, `SLR_CONV_DEF_MS}, "default period");
        $display("test reset values done");
        apb(1'b1, A_SLEW, 32'hffff_ffff);
        chk_rd(A_SLEW, 32'hffffffff, 32'h0000_7ffc);
        // low byte lane only: the upper half of the field must survive
        pstrb <= 4'h1;
        apb(1'b1, A_SLEW, 32'h0000_0000);
        pstrb <= 4'hf;
        chk_rd(A_SLEW, 32'hffffffff, 32'h0000_7f00);
        apb(1'b1, A_ID, 32'h0000_0000);
        apb(1'b1, A_SNL, 32'h0000_0000);
        chk_rd(A_ID, 32'hffffffff, {16'h0, ID_REV, ID_CODE});
        chk_rd(A_SNL, 32'hffffffff, {16'h0, SERIAL[15:0]});
        apb(1'b0, 12'h03c, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        $display("test access kinds done");
        apb(1'b1, A_CONV, 32'h0000_0001);
        chk_rd(A_CONV, 32'h00000fff, 32'h0000_0006);
        apb(1'b1, A_CONV, 32'h0000_0fff);
        chk_rd(A_CONV, 32'h00000fff, 32'h0000_07d0);
        apb(1'b1, A_CONV, 32'h0000_0006);
        wait_start();
        wait_start();
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, A_ID, 32'h0);
        end
        wait_start();
        check(last_gap, 32'h0000_003c, "period with busy bus");
        $display("test conversion period done");
        apb(1'b1, A_SLEW, 32'h0000_0500);
        apb(1'b1, A_CFG, 32'h0000_0008);
        apb(1'b1, A_IMSK, 32'h0000_0001);
        apb(1'b1, A_IST, 32'h0000_0003);
        sample(16'h0141);
        check({30'h0, alert, irq}, 32'h3, "above threshold");
        chk_rd(A_RST, 32'h1, 32'h1);
        sample(16'h0140);
        chk_rd(A_RST, 32'h1, 32'h0);
        check({31'h0, alert}, 32'h1, "sticky flag holds");
        apb(1'b1, A_IST, 32'h0000_0001);
        chk_rd(A_IST, 32'h1, 32'h0);
        check({30'h0, alert, irq}, 32'h0, "flag cleared");
        chk_rd(A_IST, 32'h2, 32'h2);
        sample(16'hfe00);
        check({31'h0, alert}, 32'h0, "negative rate");
        apb(1'b1, A_CFG, 32'h0000_0108);
        sample(16'h0200);
        check({31'h0, alert}, 32'h1, "comparator high");
        sample(16'h0000);
        check({31'h0, alert}, 32'h0, "comparator low");
        apb(1'b1, A_CFG, 32'h0000_0100);
        sample(16'h0200);
        check({30'h0, alert, irq}, 32'h1, "enable off");
        apb(1'b1, A_IMSK, 32'h0000_0000);
        // the mask write lands at the edge apb returns on
        @(negedge clk_i);
        check({31'h0, irq}, 32'h0, "masked");
        apb(1'b1, A_SLEW, 32'h0000_0000);
        sample(16'h0001);
        chk_rd(A_RST, 32'h1, 32'h1);
        $display("test rate warning done");
        finish_test();
    end
endmodule : slew_limit_and_id_registers_tb_top

// file: tb/slr_meas_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// measurement side: one rate sample per conversion start
// ----------------------------------------------------------------
module slr_meas_model #(
    parameter int unsigned LATENCY = 3
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // conversion handshake
    input  wire logic        conv_start_i,
    input  wire logic [15:0] rate_cmd_i,
    output logic [15:0]      rate_o,
    output logic             rate_valid_o
);
    int unsigned wait_q;
    logic        busy;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy         <= 1'b0;
            wait_q       <= 0;
            rate_o       <= 16'h0000;
            rate_valid_o <= 1'b0;
        end else begin
            rate_valid_o <= 1'b0;
            // the last sample and its inverse alternate on the bus between pulses
            rate_o       <= ~rate_o;
            if (conv_start_i) begin
                busy   <= 1'b1;
                wait_q <= LATENCY;
            end else if (busy && wait_q == 0) begin
                busy         <= 1'b0;
                rate_valid_o <= 1'b1;
                rate_o       <= rate_cmd_i;
            end else if (busy) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : slr_meas_model
